// ===== rtl/fwsf_consts.vh
// Constants for the single-clock buffer with status flags.
// Assumes inclusion by the buffer and its bench; definitions only.
`ifndef FWSF_CONSTS_VH
`define FWSF_CONSTS_VH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define FWSF_DW 8
`define FWSF_AW 4
`define FWSF_PW 5
`define FWSF_DEPTH 16
// ----------------------------------------
// Programmable-full styles
// ----------------------------------------
`define FWSF_PF_CONST 2'h0
`define FWSF_PF_DYN_SINGLE 2'h1
`define FWSF_PF_RANGE 2'h2
`define FWSF_PF_DYN_RANGE 2'h3
// ----------------------------------------
// Default thresholds and reset values
// ----------------------------------------
`define FWSF_PF_THRESH 5'h0c
`define FWSF_PF_ASSERT 5'h0d
`define FWSF_PF_NEGATE 5'h09
`define FWSF_PE_THRESH 5'h04
`define FWSF_PTR_RST 5'h00
`define FWSF_ONE 5'h01
`define FWSF_CNT_FULL 5'h10
`define FWSF_CNT_AFULL 5'h0f
`endif

// ===== rtl/fwsf_fifo.v
// Single-clock first-in first-out buffer with full, empty, almost, programmable
// and handshake flags. Assumes writer and reader logic on mclk; no pin inputs.
`timescale 1ns/1ns
`include "fwsf_consts.vh"
module fwsf_fifo #(
    parameter [1:0] PF_STYLE = `FWSF_PF_CONST,
    parameter [4:0] PF_THRESH = `FWSF_PF_THRESH,
    parameter [4:0] PF_ASSERT = `FWSF_PF_ASSERT,
    parameter [4:0] PF_NEGATE = `FWSF_PF_NEGATE,
    parameter [4:0] PE_THRESH = `FWSF_PE_THRESH
) (
    // System
    input wire mclk,
    input wire rst_n,
    // Write side
    input wire wen,
    input wire [`FWSF_DW-1:0] wdata,
    input wire wclr,
    output reg wr_ack,
    output reg overflow,
    output reg wfull,
    output reg almost_full,
    output reg prog_full,
    // Programmable thresholds from ports
    input wire [`FWSF_PW-1:0] prog_full_thresh,
    input wire [`FWSF_PW-1:0] prog_full_assert,
    input wire [`FWSF_PW-1:0] prog_full_negate,
    // Read side
    input wire ren,
    input wire rclr,
    output reg [`FWSF_DW-1:0] rdata,
    output reg rd_ack,
    output reg underflow,
    output reg rempty,
    output reg almost_empty,
    output reg prog_empty
);

// ----------------------------------------
// Storage and pointers
// ----------------------------------------
// Single clock, so pointers are compared directly in binary; the Gray
// crossing belongs to the dual-clock variant only.
reg [`FWSF_DW-1:0] mem [0:`FWSF_DEPTH-1];
reg [`FWSF_PW-1:0] wptr;
reg [`FWSF_PW-1:0] rptr;
wire [`FWSF_PW-1:0] next_wptr;
wire [`FWSF_PW-1:0] next_rptr;
wire [`FWSF_PW-1:0] next_cnt;
wire is_full;
wire is_empty;
wire do_wr;
wire do_rd;

function [`FWSF_PW-1:0] fwsf_count;
    input [`FWSF_PW-1:0] wp;
    input [`FWSF_PW-1:0] rp;
    begin
        fwsf_count = wp - rp;
    end
endfunction

function [`FWSF_PW-1:0] fwsf_inc;
    input [`FWSF_PW-1:0] p;
    begin
        fwsf_inc = p + `FWSF_ONE;
    end
endfunction

// Extra top bit separates full from empty at equal addresses.
assign is_full = (wptr[`FWSF_AW] != rptr[`FWSF_AW]) &&
                 (wptr[`FWSF_AW-1:0] == rptr[`FWSF_AW-1:0]);
assign is_empty = (wptr == rptr);
assign do_wr = wen && !is_full && !wclr;
assign do_rd = ren && !is_empty && !rclr;
assign next_wptr = wclr ? `FWSF_PTR_RST : (do_wr ? fwsf_inc(wptr) : wptr);
assign next_rptr = rclr ? `FWSF_PTR_RST : (do_rd ? fwsf_inc(rptr) : rptr);
assign next_cnt = fwsf_count(next_wptr, next_rptr);

// ----------------------------------------
// Programmable-full threshold selection
// ----------------------------------------
reg [`FWSF_PW-1:0] pf_set;
reg [`FWSF_PW-1:0] pf_clr;
reg pf_paired;
always @* begin
    pf_set = PF_THRESH;
    pf_clr = PF_THRESH;
    pf_paired = 1'b0;
    case (PF_STYLE)
        `FWSF_PF_CONST: begin
            pf_set = PF_THRESH;
            pf_clr = PF_THRESH;
        end
        `FWSF_PF_DYN_SINGLE: begin
            pf_set = prog_full_thresh;
            pf_clr = prog_full_thresh;
        end
        `FWSF_PF_RANGE: begin
            pf_set = PF_ASSERT;
            pf_clr = PF_NEGATE;
            pf_paired = 1'b1;
        end
        `FWSF_PF_DYN_RANGE: begin
            pf_set = prog_full_assert;
            pf_clr = prog_full_negate;
            pf_paired = 1'b1;
        end
        default: begin
            pf_set = PF_THRESH;
            pf_clr = PF_THRESH;
        end
    endcase
end

reg next_pf;
always @* begin
    if (!pf_paired) begin
        next_pf = (next_cnt >= pf_set);
    end else if (next_cnt >= pf_set) begin
        next_pf = 1'b1;
    end else if (next_cnt < pf_clr) begin
        next_pf = 1'b0;
    end else begin
        next_pf = prog_full;
    end
end

// ----------------------------------------
// Write side
// ----------------------------------------
always @(posedge mclk) begin
    if (do_wr) begin
        mem[wptr[`FWSF_AW-1:0]] <= wdata;
    end
end

// Level flags are registered from the next pointer values so that they line up
// with the pointers on the same edge; costs a little logic depth.
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        wptr <= `FWSF_PTR_RST;
    end else begin
        wptr <= next_wptr;
    end
end

// ----------------------------------------
// Write handshake
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        wr_ack <= 1'b0;
        overflow <= 1'b0;
    end else if (wclr) begin
        wr_ack <= 1'b0;
        overflow <= 1'b0;
    end else begin
        wr_ack <= do_wr;
        overflow <= wen && is_full;
    end
end

// ----------------------------------------
// Write level flags
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        wfull <= 1'b0;
    end else begin
        wfull <= (next_cnt == `FWSF_CNT_FULL);
    end
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        almost_full <= 1'b0;
    end else begin
        almost_full <= (next_cnt == `FWSF_CNT_AFULL);
    end
end

// A clear of the write side alone drops the flag at once, even in the
// paired styles, because the count it was set on no longer exists.
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        prog_full <= 1'b0;
    end else if (wclr) begin
        prog_full <= 1'b0;
    end else begin
        prog_full <= next_pf;
    end
end

// ----------------------------------------
// Read side
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rptr <= `FWSF_PTR_RST;
    end else begin
        rptr <= next_rptr;
    end
end

// The word is held between reads, so a stalled reader loses nothing.
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rdata <= {`FWSF_DW{1'b0}};
    end else if (do_rd) begin
        rdata <= mem[rptr[`FWSF_AW-1:0]];
    end
end

// ----------------------------------------
// Read handshake
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rd_ack <= 1'b0;
        underflow <= 1'b0;
    end else if (rclr) begin
        rd_ack <= 1'b0;
        underflow <= 1'b0;
    end else begin
        rd_ack <= do_rd;
        underflow <= ren && is_empty;
    end
end

// ----------------------------------------
// Read level flags
// ----------------------------------------
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        rempty <= 1'b1;
    end else begin
        rempty <= (next_wptr == next_rptr);
    end
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        almost_empty <= 1'b0;
    end else begin
        almost_empty <= (next_cnt == `FWSF_ONE);
    end
end

always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        prog_empty <= 1'b1;
    end else begin
        prog_empty <= (next_cnt <= PE_THRESH);
    end
end

endmodule

// ===== tb/fwsf_monitor.sv
// Checker of the buffer's handshake and level flags.
// Assumes a bind onto fwsf_fifo built with the dynamic paired style.
`timescale 1ns/1ns
module fwsf_monitor (
    // Watched ports
    input wire mclk,
    input wire rst_n,
    input wire wen,
    input wire ren,
    input wire wclr,
    input wire rclr,
    input wire wr_ack,
    input wire overflow,
    input wire rd_ack,
    input wire underflow,
    input wire wfull,
    input wire rempty,
    input wire almost_full,
    input wire almost_empty,
    input wire prog_full,
    input wire prog_empty
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire nc = !wclr && !rclr;
    a_wr_taken: assert property (nc && wen && !wfull |=> wr_ack && !overflow)
        else $error("accepted write not acknowledged");
    a_wr_refused: assert property (nc && wen && !ren && wfull |=> overflow && wfull)
        else $error("refused write not flagged");
    a_rd_taken: assert property (nc && ren && !rempty |=> rd_ack && !underflow)
        else $error("accepted read not acknowledged");
    a_rd_refused: assert property (nc && ren && !wen && rempty |=> underflow && rempty)
        else $error("refused read not flagged");
    a_full_drop: assert property (nc && wfull && ren && !wen |=> almost_full && !wfull)
        else $error("almost full missing below full");
    a_last_word: assert property (nc && almost_empty && ren && !wen |=> rempty)
        else $error("last read did not empty");
    a_full_prog: assert property (wfull |-> prog_full && !rempty)
        else $error("full without programmable full");
    a_clear_both: assert property (wclr && rclr |=> rempty && !wfull && !wr_ack)
        else $error("clear did not empty");
endmodule

// ===== tb/fwsf_user.sv
// Model of the user logic that feeds and drains the buffer.
// Assumes it sees the same ports as the buffer; it scores read order.
`timescale 1ns/1ns
`include "fwsf_consts.vh"
module fwsf_user (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Buffer ports and score counts
    input wire wen,
    input wire wclr,
    input wire rclr,
    input wire wfull,
    input wire rd_ack,
    input wire [`FWSF_DW-1:0] rdata,
    output reg [`FWSF_DW-1:0] wdata,
    output integer n_bad,
    output integer n_cmp
);
    reg [`FWSF_DW-1:0] q[$];
    initial n_bad = 0;
    initial n_cmp = 0;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q.delete();
            wdata <= 8'h00;
        end else if (wclr && rclr) begin
            q.delete();
        end else begin
            if (rd_ack) begin
                n_cmp = n_cmp + 1;
                if (q.size() == 0 || rdata !== q[0]) begin
                    n_bad = n_bad + 1;
                    $display("[ERR] t=%0t got=%h exp=%h", $time, rdata,
                        (q.size() != 0) ? q[0] : 8'h00);
                end
                if (q.size() != 0) q.pop_front();
            end
            if (wen && !wfull) q.push_back(wdata);
            if (wen) wdata <= wdata + 8'h01;
        end
    end
endmodule

// ===== tb/tb_fwsf_fifo.sv
// Self-checking bench for the single-clock buffer.
// Assumes the buffer, the user model and the checker are compiled first.
`timescale 1ns/1ns
`include "fwsf_consts.vh"
module tb_fwsf_fifo;
    reg mclk = 1'b0;
    reg rst_n = 1'b0;
    reg wen = 1'b0, ren = 1'b0, wclr = 1'b0, rclr = 1'b0;
    reg [4:0] pf_a = 5'h0d, pf_n = 5'h09;
    wire [7:0] wdata, rdata;
    wire wr_ack, overflow, rd_ack, underflow, wfull, rempty;
    wire almost_full, almost_empty, prog_full, prog_empty;
    wire [9:0] fl = {wr_ack, overflow, rd_ack, underflow, wfull, almost_full,
        prog_full, rempty, almost_empty, prog_empty};
    integer err_total = 0, n_compared = 0, i, k, p_bad, p_cmp;
    reg [16:0] rows [0:12];
    always #4 mclk = ~mclk;
    fwsf_fifo #(.PF_STYLE(`FWSF_PF_DYN_RANGE)) i_fwsf_fifo (.mclk(mclk), .rst_n(rst_n),
        .wen(wen), .wdata(wdata), .wclr(wclr), .wr_ack(wr_ack), .overflow(overflow),
        .wfull(wfull), .almost_full(almost_full), .prog_full(prog_full),
        .prog_full_thresh(5'h0c), .prog_full_assert(pf_a), .prog_full_negate(pf_n),
        .ren(ren), .rclr(rclr), .rdata(rdata), .rd_ack(rd_ack), .underflow(underflow),
        .rempty(rempty), .almost_empty(almost_empty), .prog_empty(prog_empty));
    fwsf_user i_fwsf_user (.mclk(mclk), .rst_n(rst_n), .wen(wen), .wclr(wclr),
        .rclr(rclr), .wfull(wfull), .rd_ack(rd_ack), .rdata(rdata), .wdata(wdata),
        .n_bad(p_bad), .n_cmp(p_cmp));
    task chk(input [9:0] got, input [9:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_total = err_total + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Requests rise after a falling edge and stay for n rising edges.
    task op(input w, input r, input [4:0] n);
        begin
            for (k = 0; k < n; k = k + 1) begin
                wen = w;
                ren = r;
                @(negedge mclk);
            end
            wen = 1'b0;
            ren = 1'b0;
        end
    endtask
    task tally_and_finish;
        begin
            err_total = err_total + p_bad;
            n_compared = n_compared + p_cmp;
            $display("compared %0d mismatched %0d", n_compared, err_total);
            if (err_total == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    initial begin
        rows = '{{2'b10, 5'h01, 10'h203}, {2'b10, 5'h0e, 10'h218}, {2'b10, 5'h01, 10'h228},
            {2'b10, 5'h01, 10'h128}, {2'b01, 5'h03, 10'h088}, {2'b01, 5'h04, 10'h088},
            {2'b01, 5'h01, 10'h080}, {2'b01, 5'h04, 10'h081}, {2'b01, 5'h03, 10'h083},
            {2'b01, 5'h01, 10'h085}, {2'b01, 5'h01, 10'h045}, {2'b10, 5'h01, 10'h203},
            {2'b11, 5'h02, 10'h283}};
        repeat (12) @(negedge mclk);
        chk(fl, 10'h005);
        rst_n = 1'b1;
        for (i = 0; i < 13; i = i + 1) begin
            op(rows[i][16], rows[i][15], rows[i][14:10]);
            chk(fl, rows[i][9:0]);
        end
        pf_a = 5'h02;
        pf_n = 5'h02;
        op(1'b1, 1'b0, 5'h01);
        chk(fl, 10'h209);
        op(1'b0, 1'b1, 5'h01);
        chk(fl, 10'h083);
        wclr = 1'b1;
        rclr = 1'b1;
        op(1'b1, 1'b0, 5'h01);
        wclr = 1'b0;
        rclr = 1'b0;
        chk(fl, 10'h005);
        op(1'b1, 1'b0, 5'h01);
        rst_n = 1'b0;
        #1 chk(fl, 10'h005);
        tally_and_finish;
    end
endmodule
bind fwsf_fifo fwsf_monitor i_fwsf_monitor (.mclk(mclk), .rst_n(rst_n), .wen(wen),
    .ren(ren), .wclr(wclr), .rclr(rclr), .wr_ack(wr_ack), .overflow(overflow),
    .rd_ack(rd_ack), .underflow(underflow), .wfull(wfull), .rempty(rempty),
    .almost_full(almost_full), .almost_empty(almost_empty), .prog_full(prog_full),
    .prog_empty(prog_empty));
